// *** common/arb_pkg.sv ***
package arb_pkg;
   // Grant vector, bit order: lo 2..0 then hi 4..0, active low
   localparam logic [7:0] all_grants_off = 8'hff;
   localparam logic [7:0] hi_grant_vec_0 = 8'hfe;
   localparam logic [7:0] lo_grant_vec_0 = 8'hdf;
   localparam logic [7:0] lo_grant_vec_1 = 8'hbf;
   localparam logic [7:0] lo_grant_vec_2 = 8'h7f;
   localparam int hi_count = 5;
   localparam int lo_count = 3;
   localparam int sync_stages = 2;
   localparam logic [2:0] idle_upper = 3'h7;
   localparam logic [2:0] idle_low_min = 3'h3;
   localparam logic [2:0] idle_lower_0 = 3'h7;
   localparam logic [2:0] lo_upper_0 = 3'h5;
   localparam logic [2:0] lo_upper_1 = 3'h6;
   localparam logic [2:0] lo_upper_2 = 3'h4;

   typedef enum logic [5:0] {
      st_idle_0 = 6'h3f,
      st_idle_1 = 6'h3e,
      st_idle_2 = 6'h3d,
      st_idle_3 = 6'h3c,
      st_idle_4 = 6'h3b,
      st_hi_grant_0 = 6'h06,
      st_hi_grant_1 = 6'h07,
      st_hi_grant_2 = 6'h0e,
      st_hi_grant_3 = 6'h0f,
      st_hi_grant_4 = 6'h16
   } state_e;
endpackage

// *** rtl/req_sync.sv ***
`timescale 1ns/1ps
module req_sync #(
   parameter int width = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [width-1:0] async_n,
   output logic [width-1:0] sync_n
);
   logic [width-1:0] meta_reg;
   logic [width-1:0] meta_next;
   logic [width-1:0] sync_reg;
   logic [width-1:0] sync_next;

   // Two-stage synchroniser, idles at released level
   always_comb begin
      meta_next = async_n;
      sync_next = meta_reg;
      if (rst) begin
         meta_next = '1;
         sync_next = '1;
      end
   end

   always_ff @(posedge clk) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
   end

   assign sync_n = sync_reg;
endmodule

// *** rtl/rotating_priority_arbiter.sv ***
`timescale 1ns/1ps
// How it works
// RL1: Eight active-low grants, lo 2..0 then hi 4..0; one zero, FFh none.
// RL2: Idle states 3Fh..3Bh for idle 0..4, all upper bits 111.
// RL3: High grant states 06h, 07h, 0Eh, 0Fh, 16h for requesters 0..4.
// RL4: Low grant upper bits 101, 110, 100; lower bits keep exited idle.
// RL5: Idle m grants high m first, then m+1 onward modulo five.
// RL6: High grant n released goes to idle (n+1) mod 5, grants off.
// RL7: Low grants only when all high requests high; low 0 first.
// RL8: Low grant released returns to its idle by forcing upper bits to one.
// RL9: Grant holds with one grant low while its request stays low.
// RL10: One idle clock with no grant between any two grants.
// RL11: Reset forces state and grant bits to one: idle 0, no grant.
// RL12: High logic chooses next state unless low path applies.
// RL13: Grants decoded from next state, registered with the state.
// RL14: Requests pass a clocked synchroniser before the state machine.
// RL15: Unused state code goes to idle 0 with grants off.
module rotating_priority_arbiter (
   input wire logic clk,
   input wire logic rst,
   input wire logic hi_req_0_n,
   input wire logic hi_req_1_n,
   input wire logic hi_req_2_n,
   input wire logic hi_req_3_n,
   input wire logic hi_req_4_n,
   input wire logic lo_req_0_n,
   input wire logic lo_req_1_n,
   input wire logic lo_req_2_n,
   output logic [7:0] grant_n,
   output logic [5:0] state_bits
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] req_raw_n;
   logic [7:0] req_n;
   logic [4:0] hi_n;
   logic [2:0] lo_n;
   logic [5:0] state_reg;
   logic [5:0] next_state_bits;
   logic [7:0] grant_reg;
   logic [7:0] grant_next;
   logic [5:0] hi_next;
   logic [5:0] lo_next;
   logic lo_path;
   logic is_lo_grant;

   // Request inputs
   assign req_raw_n = {lo_req_2_n, lo_req_1_n, lo_req_0_n, hi_req_4_n, hi_req_3_n,
                       hi_req_2_n, hi_req_1_n, hi_req_0_n};

   req_sync #(.width(8)) u_sync ( // [RL14]
      .clk(clk),
      .rst(rst),
      .async_n(req_raw_n),
      .sync_n(req_n)
   );

   assign hi_n = req_n[4:0];
   assign lo_n = req_n[7:5];

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers
   function automatic logic [5:0] idle_code(input int m);
      unique case (m)
         0: idle_code = arb_pkg::st_idle_0;
         1: idle_code = arb_pkg::st_idle_1;
         2: idle_code = arb_pkg::st_idle_2;
         3: idle_code = arb_pkg::st_idle_3;
         default: idle_code = arb_pkg::st_idle_4;
      endcase
   endfunction

   function automatic logic [5:0] hi_code(input int n);
      unique case (n)
         0: hi_code = arb_pkg::st_hi_grant_0;
         1: hi_code = arb_pkg::st_hi_grant_1;
         2: hi_code = arb_pkg::st_hi_grant_2;
         3: hi_code = arb_pkg::st_hi_grant_3;
         default: hi_code = arb_pkg::st_hi_grant_4;
      endcase
   endfunction

   // Active-low grant for high requester n
   function automatic logic [7:0] hi_vec(input int n);
      hi_vec = ~(~arb_pkg::hi_grant_vec_0 << n); // [RL1]
   endfunction

   // Grant vector from a state code; upper bits 101, 110, 100 give a low grant whatever the lower bits, other unused codes no grant
   function automatic logic [7:0] grant_of(input logic [5:0] s);
      logic [7:0] g;
      g = arb_pkg::all_grants_off;
      for (int i = 0; i < arb_pkg::hi_count; i++) begin
         if (s == hi_code(i)) begin
            g = hi_vec(i); // [RL1]
         end
      end
      unique case (s[5:3])
         arb_pkg::lo_upper_0: g = arb_pkg::lo_grant_vec_0;
         arb_pkg::lo_upper_1: g = arb_pkg::lo_grant_vec_1;
         arb_pkg::lo_upper_2: g = arb_pkg::lo_grant_vec_2;
         default: ;
      endcase
      grant_of = g;
   endfunction

   // Low grant code: upper bits name the class, lower bits a valid idle
   function automatic logic lo_state(input logic [5:0] s);
      lo_state = ((s[5:3] == arb_pkg::lo_upper_0) || (s[5:3] == arb_pkg::lo_upper_1) ||
                  (s[5:3] == arb_pkg::lo_upper_2)) && (s[2:0] >= arb_pkg::idle_low_min);
   endfunction

   // Valid idle code: upper bits all one, lower bits 3..7
   function automatic logic is_idle(input logic [5:0] s);
      is_idle = (s[5:3] == arb_pkg::idle_upper) && (s[2:0] >= arb_pkg::idle_low_min); // [RL2]
   endfunction

   // Idle number m: 3Fh is idle 0 down to 3Bh for idle 4
   function automatic int idle_index(input logic [5:0] s);
      idle_index = int'(arb_pkg::idle_lower_0 - s[2:0]);
   endfunction

   // First pending high requester from m onward, modulo five; -1 if none
   function automatic int first_hi(input int m, input logic [4:0] req);
      int k;
      first_hi = -1;
      for (int j = arb_pkg::hi_count - 1; j >= 0; j--) begin
         k = (m + j) % arb_pkg::hi_count;
         if (!req[k]) begin
            first_hi = k; // [RL5]
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // High-class decision
   always_comb begin
      int pick;
      pick = first_hi(idle_index(state_reg), hi_n);
      hi_next = state_reg; // [RL9]
      unique case (state_reg)
         arb_pkg::st_idle_0,
         arb_pkg::st_idle_1,
         arb_pkg::st_idle_2,
         arb_pkg::st_idle_3,
         arb_pkg::st_idle_4: begin
            if (pick >= 0) begin
               hi_next = hi_code(pick); // [RL5]
            end
         end
         arb_pkg::st_hi_grant_0: begin
            if (hi_n[0]) begin
               hi_next = idle_code(1); // [RL6] [RL10]
            end
         end
         arb_pkg::st_hi_grant_1: begin
            if (hi_n[1]) begin
               hi_next = idle_code(2); // [RL6]
            end
         end
         arb_pkg::st_hi_grant_2: begin
            if (hi_n[2]) begin
               hi_next = idle_code(3); // [RL6]
            end
         end
         arb_pkg::st_hi_grant_3: begin
            if (hi_n[3]) begin
               hi_next = idle_code(4); // [RL6]
            end
         end
         arb_pkg::st_hi_grant_4: begin
            if (hi_n[4]) begin
               hi_next = idle_code(0); // [RL6]
            end
         end
         default: begin
            hi_next = arb_pkg::st_idle_0; // [RL15]
         end
      endcase
   end

   // Low-class decision
   always_comb begin
      is_lo_grant = lo_state(state_reg);
      lo_next = state_reg;
      if (is_lo_grant) begin
         unique case (state_reg[5:3])
            arb_pkg::lo_upper_0: begin
               if (lo_n[0]) begin
                  lo_next = {arb_pkg::idle_upper, state_reg[2:0]}; // [RL8]
               end
            end
            arb_pkg::lo_upper_1: begin
               if (lo_n[1]) begin
                  lo_next = {arb_pkg::idle_upper, state_reg[2:0]}; // [RL8]
               end
            end
            default: begin
               if (lo_n[2]) begin
                  lo_next = {arb_pkg::idle_upper, state_reg[2:0]}; // [RL8]
               end
            end
         endcase
      end else if (!lo_n[0]) begin
         lo_next = {arb_pkg::lo_upper_0, state_reg[2:0]}; // [RL4] [RL7]
      end else if (!lo_n[1]) begin
         lo_next = {arb_pkg::lo_upper_1, state_reg[2:0]};
      end else begin
         lo_next = {arb_pkg::lo_upper_2, state_reg[2:0]};
      end
      // Low path from a valid idle state with a low but no high request, or in low grant
      lo_path = is_lo_grant || ((&hi_n) && !(&lo_n) && is_idle(state_reg)); // [RL12]
   end

   ////////////////////////////////////////////////////////////////////////////
   // State and grant registers
   always_comb begin
      next_state_bits = lo_path ? lo_next : hi_next; // [RL12]
      grant_next = grant_of(next_state_bits); // [RL13]
      if (rst) begin
         next_state_bits = arb_pkg::st_idle_0; // [RL11]
         grant_next = arb_pkg::all_grants_off; // [RL11]
      end
   end

   always_ff @(posedge clk) begin
      state_reg <= next_state_bits; // [RL2] [RL3]
      grant_reg <= grant_next; // [RL13]
   end

   assign grant_n = grant_reg;
   assign state_bits = state_reg;
endmodule

// *** bench/arb_props.sv ***
`timescale 1ns/1ps
module arb_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic hi_req_0_n,
   input wire logic hi_req_1_n,
   input wire logic hi_req_2_n,
   input wire logic hi_req_3_n,
   input wire logic hi_req_4_n,
   input wire logic lo_req_0_n,
   input wire logic lo_req_1_n,
   input wire logic lo_req_2_n,
   input wire logic [7:0] grant_n,
   input wire logic [5:0] state_bits
);
   logic [7:0] exp_g;
   logic all_hi;
   assign all_hi = &{hi_req_0_n, hi_req_1_n, hi_req_2_n, hi_req_3_n, hi_req_4_n};
   // Grant implied by the state code
   always_comb begin
      casez (state_bits)
         6'h06: exp_g = 8'hfe;
         6'h07: exp_g = 8'hfd;
         6'h0e: exp_g = 8'hfb;
         6'h0f: exp_g = 8'hf7;
         6'h16: exp_g = 8'hef;
         6'b101???: exp_g = 8'hdf;
         6'b110???: exp_g = 8'hbf;
         6'b100???: exp_g = 8'h7f;
         default: exp_g = 8'hff;
      endcase
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence hi1_off;
      hi_req_1_n[*3] ##0 state_bits == 6'h07;
   endsequence
   sequence lo0_off;
      lo_req_0_n[*3] ##0 state_bits[5:3] == 3'h5;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   reset_values_a: assert property ($fell(rst) |-> grant_n == 8'hff && state_bits == 6'h3f)
      else $error("bad reset values");
   one_grant_a: assert property (grant_n != 8'hff |-> $onehot(~grant_n))
      else $error("grant not one-hot");
   grant_decode_a: assert property (grant_n == exp_g)
      else $error("grant and state disagree");
   idle_codes_a: assert property (state_bits[5:3] == 3'h7 |-> state_bits[2:0] >= 3'h3)
      else $error("bad idle code");
   guard_band_a: assert property (grant_n != 8'hff |=> grant_n == 8'hff || $stable(grant_n))
      else $error("grant switched without idle");
   hi_release_a: assert property (hi1_off |=> state_bits == 6'h3d && grant_n == 8'hff)
      else $error("release did not rotate");
   hi_hold_a: assert property (!hi_req_1_n[*3] ##0 state_bits == 6'h07 |=> $stable(state_bits))
      else $error("grant dropped early");
   idle_first_a: assert property (!hi_req_0_n[*3] ##0 state_bits == 6'h3f |=> grant_n == 8'hfe)
      else $error("idle owner not served");
   lo_blocked_a: assert property (grant_n[7:5] != 3'h7 && $past(grant_n) == 8'hff |-> $past(all_hi, 3))
      else $error("low grant while high pending");
   lo_return_a: assert property (lo0_off |=> state_bits == {3'h7, $past(state_bits[2:0])})
      else $error("low grant left wrong idle");
endmodule
bind rotating_priority_arbiter arb_props chk (.clk(clk), .rst(rst), .hi_req_0_n(hi_req_0_n),
   .hi_req_1_n(hi_req_1_n), .hi_req_2_n(hi_req_2_n), .hi_req_3_n(hi_req_3_n),
   .hi_req_4_n(hi_req_4_n), .lo_req_0_n(lo_req_0_n), .lo_req_1_n(lo_req_1_n),
   .lo_req_2_n(lo_req_2_n), .grant_n(grant_n), .state_bits(state_bits));

// *** bench/requesters.sv ***
`timescale 1ns/1ps
// Processors: request while wanted, release after hold granted cycles
module requesters #(
   parameter int hold = 3
) (
   input wire logic clk,
   input wire logic [7:0] want,
   input wire logic [7:0] grant_n,
   output logic [7:0] req_n
);
   logic [7:0] done = 8'h00;
   int cnt [8] = '{default: 0};
   assign req_n = ~(want & ~done);
   always @(posedge clk) begin
      for (int i = 0; i < 8; i++) begin
         cnt[i] <= !want[i] ? 0 : cnt[i] + int'(grant_n[i] === 1'b0);
         done[i] <= want[i] && (done[i] || cnt[i] == hold);
      end
   end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] want = 8'h00;
   logic [7:0] req_n;
   logic [7:0] grant_n;
   logic [5:0] state_bits;
   logic [7:0] prev = 8'hff;
   logic [13:0] seen [$];
   int err_total = 0;
   int checks_done = 0;
   always #5 clk = ~clk;
   rotating_priority_arbiter DUT (.clk(clk), .rst(rst), .hi_req_0_n(req_n[0]),
      .hi_req_1_n(req_n[1]), .hi_req_2_n(req_n[2]), .hi_req_3_n(req_n[3]),
      .hi_req_4_n(req_n[4]), .lo_req_0_n(req_n[5]), .lo_req_1_n(req_n[6]),
      .lo_req_2_n(req_n[7]), .grant_n(grant_n), .state_bits(state_bits));
   requesters #(.hold(3)) peers (.clk(clk), .want(want), .grant_n(grant_n), .req_n(req_n));
   // Record each new grant with its state code
   always @(negedge clk) begin
      if (grant_n !== 8'hff && prev === 8'hff)
         seen.push_back({grant_n, state_bits});
      prev = grant_n;
   end
   task automatic check(input logic [13:0] got, input logic [13:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic run(input string name, input logic [7:0] mask, input logic [13:0] exp [$]);
      int n;
      seen.delete();
      @(posedge clk);
      #1 want = mask;
      n = 0;
      while (seen.size() < exp.size() && n < 300) begin
         @(posedge clk);
         n++;
      end
      repeat (8) @(posedge clk);
      #1 want = 8'h00;
      repeat (4) @(posedge clk);
      check(14'(seen.size()), 14'(exp.size()));
      foreach (exp[i]) check(seen[i], exp[i]);
      $display("test %s done", name);
   endtask
   task automatic test_reset();
      #1 rst = 1'b1;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      repeat (2) @(posedge clk);
      #1 check({grant_n, state_bits}, {8'hff, 6'h3f});
      $display("test reset done");
   endtask
   task automatic test_rotation();
      run("rotation", 8'hff, '{{8'hfe, 6'h06}, {8'hfd, 6'h07}, {8'hfb, 6'h0e}, {8'hf7, 6'h0f},
         {8'hef, 6'h16}, {8'hdf, 6'h2f}, {8'hbf, 6'h37}, {8'h7f, 6'h27}});
   endtask
   task automatic test_wrap();
      run("single", 8'h02, '{{8'hfd, 6'h07}});
      run("wrap", 8'h09, '{{8'hf7, 6'h0f}, {8'hfe, 6'h06}});
   endtask
   task automatic test_lo_return();
      run("low", 8'h80, '{{8'h7f, 6'h26}});
      run("return", 8'h03, '{{8'hfd, 6'h07}, {8'hfe, 6'h06}});
   endtask
   task automatic test_latency();
      int n;
      @(posedge clk);
      #1 want = 8'h0c;
      repeat (2) @(posedge clk);
      #1 check({grant_n, state_bits}, {8'hff, 6'h3e});
      @(posedge clk);
      #1 check({grant_n, state_bits}, {8'hfb, 6'h0e});
      n = 0;
      while (grant_n == 8'hfb && n < 50) begin
         @(posedge clk);
         #1 n++;
      end
      check({grant_n, state_bits}, {8'hff, 6'h3c});
      @(posedge clk);
      #1 check({grant_n, state_bits}, {8'hf7, 6'h0f});
      want = 8'h00;
      repeat (6) @(posedge clk);
      #1 check({grant_n, state_bits}, {8'hff, 6'h3b});
      $display("test latency done");
   endtask
   initial begin
      #20000;
      err_total++;
      end_of_test();
   end
   initial begin
      @(posedge clk);
      test_reset();
      test_rotation();
      test_wrap();
      test_lo_return();
      test_latency();
      test_reset();
      end_of_test();
   end
endmodule
